// >>> verilog/bxs_cfg.svh
`ifndef BXS_CFG_SVH
`define BXS_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define BXS_DATA_W 8
`define BXS_ADDR_W 7
`define BXS_FILE_ADDR_MAX 7'h7F

// ----------------------------------------------------------------
// Destination select encoding
// ----------------------------------------------------------------
`define BXS_DEST_ACC 1'b0
`define BXS_DEST_FILE 1'b1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BXS_ACC_RST 8'h00
`define BXS_FLAG_RST 1'b0
`define BXS_ADDR_RST 7'h00
`define BXS_DATA_RST 8'h00

// ----------------------------------------------------------------
// Timing: cycles from accepted operation to registered result
// ----------------------------------------------------------------
`define BXS_LATENCY 1

`endif

// >>> verilog/bxs_pkg.sv
package bxs_pkg;

    // ----------------------------------------------------------------
    // Operation codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BXS_OP_SUB = 2'h0,
        BXS_OP_XOR = 2'h1,
        BXS_OP_SWAP = 2'h3,
        BXS_OP_RSVD = 2'h2
    } bxs_op_t;

endpackage : bxs_pkg

// >>> verilog/bxs_op_unit.sv
`timescale 1ns/100ps
`include "bxs_cfg.svh"

module bxs_op_unit #(
    parameter int DATA_W = `BXS_DATA_W
) (
    input bxs_pkg::bxs_op_t op_code,
    input logic [DATA_W-1:0] file_val,
    input logic [DATA_W-1:0] acc_val,
    output logic [DATA_W-1:0] result,
    output logic carry,
    output logic half_carry,
    output logic zero,
    output logic upd_carry,
    output logic upd_half,
    output logic upd_zero
);
    import bxs_pkg::*;

    localparam int HALF_W = DATA_W / 2;

    logic [DATA_W:0] diff;
    logic [HALF_W:0] half_diff;

    // ----------------------------------------------------------------
    // Two's complement subtract, file minus accumulator
    // ----------------------------------------------------------------
    // Carry out of f + ~W + 1 is the inverted borrow
    assign diff = {1'b0, file_val} + {1'b0, ~acc_val} + {{DATA_W{1'b0}}, 1'b1};
    assign half_diff = {1'b0, file_val[HALF_W-1:0]} + {1'b0, ~acc_val[HALF_W-1:0]}
                       + {{HALF_W{1'b0}}, 1'b1};

    // ----------------------------------------------------------------
    // Result and flag selection
    // ----------------------------------------------------------------
    // Update enables keep untouched flags out of the status write
    always_comb begin
        result = file_val;
        upd_carry = 1'b0;
        upd_half = 1'b0;
        upd_zero = 1'b0;
        case (op_code)
            BXS_OP_SUB: begin
                result = diff[DATA_W-1:0];
                upd_carry = 1'b1;
                upd_half = 1'b1;
                upd_zero = 1'b1;
            end
            BXS_OP_XOR: begin
                result = acc_val ^ file_val;
                upd_zero = 1'b1;
            end
            BXS_OP_SWAP: begin
                result = {file_val[HALF_W-1:0], file_val[DATA_W-1:HALF_W]};
            end
            default: begin
                result = file_val;
            end
        endcase
    end

    assign carry = diff[DATA_W];
    assign half_carry = half_diff[HALF_W];
    assign zero = (result == {DATA_W{1'b0}});

endmodule : bxs_op_unit

// >>> verilog/bxs_alu.sv
`timescale 1ns/100ps
`include "bxs_cfg.svh"

// Function
// - Subtract gives file minus accumulator in two's complement and sets C, half carry and Z.
// - Destination 0 sends the result to the accumulator and 1 writes it back to the file.
// - Exclusive OR of accumulator and file value changes only the zero flag.
// - Nibble exchange puts file bits 3:0 in result 7:4 and 7:4 in 3:0, with no flag change.
module bxs_alu #(
    parameter int DATA_W = `BXS_DATA_W,
    parameter int ADDR_W = `BXS_ADDR_W
) (
    input wire core_clk,
    input wire reset_n,
    input wire op_valid,
    input bxs_pkg::bxs_op_t op_code,
    input wire [ADDR_W-1:0] file_addr,
    input wire dest_sel,
    input wire [DATA_W-1:0] file_data,
    input wire acc_load,
    input wire [DATA_W-1:0] acc_load_data,
    output logic [DATA_W-1:0] acc_q,
    output logic carry_q,
    output logic half_byte_carry_flag_q,
    output logic zero_q,
    output logic file_wr_en_q,
    output logic [ADDR_W-1:0] file_wr_addr_q,
    output logic [DATA_W-1:0] file_wr_data_q,
    output logic [DATA_W-1:0] result_q,
    output logic done_q,
    output logic illegal_q
);
    import bxs_pkg::*;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Reserved code is refused rather than treated as a no-op write
    function automatic logic op_is_known(input bxs_op_t op);
        op_is_known = (op == BXS_OP_SUB) || (op == BXS_OP_XOR) || (op == BXS_OP_SWAP);
    endfunction : op_is_known

    logic op_take;
    logic to_file;
    logic [DATA_W-1:0] alu_result;
    logic alu_carry;
    logic alu_half;
    logic alu_zero;
    logic upd_carry;
    logic upd_half;
    logic upd_zero;

    assign op_take = op_valid && op_is_known(op_code);
    // Single select bit: no other value can reach the steering
    assign to_file = (dest_sel == `BXS_DEST_FILE);

    // ----------------------------------------------------------------
    // Combinational operation unit
    // ----------------------------------------------------------------
    bxs_op_unit #(
        .DATA_W(DATA_W)
    ) u_op (
        .op_code(op_code),
        .file_val(file_data),
        .acc_val(acc_q),
        .result(alu_result),
        .carry(alu_carry),
        .half_carry(alu_half),
        .zero(alu_zero),
        .upd_carry(upd_carry),
        .upd_half(upd_half),
        .upd_zero(upd_zero)
    );

    // ----------------------------------------------------------------
    // Accumulator
    // ----------------------------------------------------------------
    // An operation beats a direct load in the same cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= `BXS_ACC_RST;
        end else if (op_take && !to_file) begin
            acc_q <= alu_result;
        end else if (acc_load && !op_valid) begin
            acc_q <= acc_load_data;
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    // Each flag moves only when its operation owns it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            carry_q <= `BXS_FLAG_RST;
            half_byte_carry_flag_q <= `BXS_FLAG_RST;
            zero_q <= `BXS_FLAG_RST;
        end else if (op_take) begin
            if (upd_carry) begin
                carry_q <= alu_carry;
            end
            if (upd_half) begin
                half_byte_carry_flag_q <= alu_half;
            end
            if (upd_zero) begin
                zero_q <= alu_zero;
            end
        end
    end

    // ----------------------------------------------------------------
    // File register write-back
    // ----------------------------------------------------------------
    // Address and data hold after the strobe so the file can sample late
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            file_wr_en_q <= 1'b0;
            file_wr_addr_q <= `BXS_ADDR_RST;
            file_wr_data_q <= `BXS_DATA_RST;
        end else begin
            file_wr_en_q <= op_take && to_file;
            if (op_take && to_file) begin
                file_wr_addr_q <= file_addr;
                file_wr_data_q <= alu_result;
            end
        end
    end

    // ----------------------------------------------------------------
    // Result, completion and refusal
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_q <= `BXS_DATA_RST;
            done_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            done_q <= op_take;
            illegal_q <= op_valid && !op_is_known(op_code);
            if (op_take) begin
                result_q <= alu_result;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_sub_issue;
        op_valid && (op_code == BXS_OP_SUB);
    endsequence

    sequence s_xor_issue;
        op_valid && (op_code == BXS_OP_XOR);
    endsequence

    sequence s_swap_issue;
        op_valid && (op_code == BXS_OP_SWAP);
    endsequence

    sequence s_to_acc;
        op_take && (dest_sel == `BXS_DEST_ACC);
    endsequence

    sequence s_to_file;
        op_take && (dest_sel == `BXS_DEST_FILE);
    endsequence

    a_sub_value: assert property (s_sub_issue |=>
        result_q == DATA_W'($past(file_data) - $past(acc_q)))
        else $error("subtract result wrong");

    a_sub_flags: assert property (s_sub_issue |=>
        (carry_q == ($past(file_data) >= $past(acc_q)))
        && (half_byte_carry_flag_q == ($past(file_data[3:0]) >= $past(acc_q[3:0])))
        && (zero_q == (result_q == '0)))
        else $error("subtract flags wrong");

    a_dest_acc: assert property (s_to_acc |=>
        (acc_q == result_q) && !file_wr_en_q && done_q)
        else $error("accumulator destination not honoured");

    a_dest_file: assert property (s_to_file |=>
        file_wr_en_q && (file_wr_data_q == result_q) && (acc_q == $past(acc_q)))
        else $error("file destination not honoured");

    a_idle_quiet: assert property (!op_take |=> !file_wr_en_q && !done_q)
        else $error("spurious write or completion");

    a_xor_zero_only: assert property (s_xor_issue |=>
        (result_q == ($past(acc_q) ^ $past(file_data))) && $stable(carry_q)
        && $stable(half_byte_carry_flag_q) && (zero_q == (result_q == '0)))
        else $error("xor result or flags wrong");

    a_swap_no_flags: assert property (s_swap_issue |=>
        (result_q == {$past(file_data[3:0]), $past(file_data[7:4])})
        && $stable(carry_q) && $stable(half_byte_carry_flag_q) && $stable(zero_q))
        else $error("swap result or flags wrong");

    a_addr_carry: assert property (s_to_file ##1 !op_take |=>
        file_wr_addr_q == $past(file_addr, 2))
        else $error("write address not held");

endmodule : bxs_alu

// >>> verif/bxs_file_model.sv
`timescale 1ns/100ps

// Behavioural file register bank on the far side of the datapath
module bxs_file_model (
    input wire core_clk,
    input wire [6:0] file_addr,
    input wire file_wr_en_q,
    input wire [6:0] file_wr_addr_q,
    input wire [7:0] file_wr_data_q,
    output logic [7:0] file_data
);
    import bxs_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] mem_q [0:127];

    // Known start pattern so the bench can mirror it
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem_q[i] = 8'(i * 29 + 90);
        end
    end

    // Write-back on the strobe, one byte per pulse
    always @(posedge core_clk) begin
        if (file_wr_en_q) begin
            mem_q[file_wr_addr_q] <= file_wr_data_q;
        end
    end

    // Bypass so a read right after a write sees the new byte
    assign file_data = (file_wr_en_q && file_wr_addr_q == file_addr) ? file_wr_data_q
                       : mem_q[file_addr];

endmodule : bxs_file_model

// >>> verif/tb_top.sv
`timescale 1ns/100ps

module tb_top;
    import bxs_pkg::*;

    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic op_valid = 1'b0;
    bxs_op_t op_code = BXS_OP_SUB;
    logic [6:0] file_addr = 7'h00;
    logic dest_sel = 1'b0;
    logic [7:0] file_data;
    logic acc_load = 1'b0;
    logic [7:0] acc_load_data = 8'h00;
    logic [7:0] acc_q, file_wr_data_q, result_q;
    logic carry_q, half_byte_carry_flag_q, zero_q, file_wr_en_q, done_q, illegal_q;
    logic [6:0] file_wr_addr_q;
    logic [7:0] mirror [0:127];
    logic [7:0] e_acc = 8'h00, e_res = 8'h00, e_wd = 8'h00;
    logic [6:0] e_wa = 7'h00;
    logic e_c = 1'b0, e_hc = 1'b0, e_z = 1'b0, e_done = 1'b0, e_we = 1'b0, e_ill = 1'b0;
    wire [7:0] flags_seen = {5'h00, carry_q, half_byte_carry_flag_q, zero_q};
    int bad_count = 0;
    int compares = 0;
    int seed = 35;
    logic [31:0] r;

    always #12.5 core_clk = ~core_clk;

    bxs_alu u_dut (.core_clk(core_clk), .reset_n(reset_n), .op_valid(op_valid),
        .op_code(op_code), .file_addr(file_addr), .dest_sel(dest_sel),
        .file_data(file_data), .acc_load(acc_load), .acc_load_data(acc_load_data),
        .acc_q(acc_q), .carry_q(carry_q), .half_byte_carry_flag_q(half_byte_carry_flag_q),
        .zero_q(zero_q), .file_wr_en_q(file_wr_en_q), .file_wr_addr_q(file_wr_addr_q),
        .file_wr_data_q(file_wr_data_q), .result_q(result_q), .done_q(done_q),
        .illegal_q(illegal_q));

    bxs_file_model u_file (.core_clk(core_clk), .file_addr(file_addr),
        .file_wr_en_q(file_wr_en_q), .file_wr_addr_q(file_wr_addr_q),
        .file_wr_data_q(file_wr_data_q), .file_data(file_data));

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Reference step: expected state after the op now on the inputs
    task automatic predict();
        logic [7:0] f, res;
        e_done = 1'b0;
        e_we = 1'b0;
        e_ill = op_valid && op_code == BXS_OP_RSVD;
        if (op_valid && !e_ill) begin
            f = mirror[file_addr];
            case (op_code)
                BXS_OP_SUB: begin
                    res = f - e_acc;
                    e_c = f >= e_acc;
                    e_hc = f[3:0] >= e_acc[3:0];
                    e_z = res == 8'h00;
                end
                BXS_OP_XOR: begin
                    res = f ^ e_acc;
                    e_z = res == 8'h00;
                end
                default: res = {f[3:0], f[7:4]};
            endcase
            e_res = res;
            e_done = 1'b1;
            if (dest_sel) begin
                e_we = 1'b1;
                e_wa = file_addr;
                e_wd = res;
                mirror[file_addr] = res;
            end else begin
                e_acc = res;
            end
        end else if (!op_valid && acc_load) begin
            e_acc = acc_load_data;
        end
    endtask : predict

    // Present one cycle of inputs, check the previous cycle's outcome
    task automatic step(input logic v, input bxs_op_t op, input logic [6:0] a,
                        input logic d, input logic ld, input logic [7:0] ldd);
        @(posedge core_clk);
        op_valid <= v;
        op_code <= op;
        file_addr <= a;
        dest_sel <= d;
        acc_load <= ld;
        acc_load_data <= ldd;
        #1;
        chk(acc_q, e_acc);
        chk(result_q, e_res);
        chk(flags_seen, {5'h00, e_c, e_hc, e_z});
        chk({5'h00, done_q, file_wr_en_q, illegal_q}, {5'h00, e_done, e_we, e_ill});
        if (e_we) begin
            chk({1'b0, file_wr_addr_q}, {1'b0, e_wa});
            chk(file_wr_data_q, e_wd);
        end
        predict();
    endtask : step

    // ----------------------------------------------------------------
    // Main sequence: corners first, then random back-to-back ops
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 128; i++) begin
            mirror[i] = 8'(i * 29 + 90);
        end
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        step(1'b0, BXS_OP_SUB, 7'h00, 1'b0, 1'b1, mirror[5]);
        step(1'b1, BXS_OP_SUB, 7'h05, 1'b0, 1'b0, 8'h00); // equal operands give zero
        step(1'b0, BXS_OP_SUB, 7'h00, 1'b0, 1'b1, 8'hFF);
        step(1'b1, BXS_OP_SUB, 7'h7F, 1'b1, 1'b0, 8'h00); // borrow, top address
        step(1'b1, BXS_OP_SUB, 7'h7F, 1'b0, 1'b0, 8'h00); // reads back the write
        step(1'b1, BXS_OP_RSVD, 7'h00, 1'b1, 1'b1, 8'hA5); // refused, load ignored
        step(1'b1, BXS_OP_XOR, 7'h00, 1'b1, 1'b1, 8'h3C); // load ignored under op
        step(1'b1, BXS_OP_SWAP, 7'h00, 1'b0, 1'b0, 8'h00);
        for (int n = 0; n < 400; n++) begin
            r = $random(seed);
            step(r[0] | r[1], bxs_op_t'(r[3:2]), r[10:4], r[11], r[12], r[20:13]);
        end
        step(1'b0, BXS_OP_SUB, 7'h00, 1'b0, 1'b0, 8'h00);
        step(1'b0, BXS_OP_SUB, 7'h00, 1'b0, 1'b0, 8'h00);
        end_of_test();
    end

    // Watchdog: the run needs about 420 cycles
    initial begin
        #50000;
        bad_count++;
        end_of_test();
    end

endmodule : tb_top
